// ### verilog/board_control.sv
/*
  Upper control word of the analog input board, its power-up configuration
  sequencer and software initialization. Assumes a simple register port
  (address, write strobe, read strobe) from the PCI target, and status
  inputs from the calibration, clock and buffer logic elsewhere.
*/
`timescale 1ns/1ps
`default_nettype none
`include "board_ctl_defines.svh"
module board_control #(
  parameter int EEPROM_CYC = `EEPROM_MS * `MS_CYC,
  parameter int ROM_CYC = `ROM_MS * `MS_CYC,
  parameter int LOGIC_CYC = `LOGIC_MS * `MS_CYC,
  parameter int ADC_CYC = `ADC_MS * `MS_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] i_wdata,
  output logic [31:0] o_rdata,
  output logic o_retry,
  input wire logic i_irq_event,
  input wire logic i_cal_start,
  input wire logic i_cal_fail,
  input wire logic i_param_change,
  input wire logic i_clk_stable,
  input wire logic [17:0] i_fill_count,
  input wire logic [17:0] i_threshold,
  input wire logic i_gen_a_clk,
  input wire logic i_grp0_clk,
  input wire logic i_grp0_ext_clk,
  output logic o_irq,
  output logic o_pci_irq_en,
  output logic o_sync_scan,
  output logic o_converter_sync,
  output logic o_ext_sync_out,
  output logic o_buffer_clear,
  output logic o_clk_out,
  output logic o_low_freq_filter,
  output logic o_ttl_sync,
  output logic o_trig_armed,
  output logic o_trig_invert,
  output logic [1:0] o_input_function_field,
  output logic [1:0] o_span,
  output logic o_init_pulse,
  output logic [17:0] o_threshold_load,
  output logic [4:0] o_data_width_bits,
  output logic [7:0] o_rate_divisor,
  output logic o_groups_on_a,
  output logic o_initiator
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    board_ctl_pkg::cfg_state_t st;
    logic [31:0] main_control_word;
    logic [31:0] rdata;
    logic retry;
    logic pci_irq_en;
    logic conv_sync;
    logic ext_sync;
    logic buf_clr;
    logic clk_out;
    logic init_pulse;
    logic soft_init;
    logic timer_start;
    logic [31:0] timer_load;
  } ctl_state_t;
  ctl_state_t s, next_s;
  phase_timer_if tif ();
  logic [2:0] clk_pins;
  logic gen_a_s, grp0_s, grp0_ext_s;
  logic [31:0] status_view;

  // generator clocks come from other domains, so resynchronise them
  sync_2ff #(.W(3)) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d({i_gen_a_clk, i_grp0_clk, i_grp0_ext_clk}),
    .o_q(clk_pins)
  );
  assign gen_a_s = clk_pins[2];
  assign grp0_s = clk_pins[1];
  assign grp0_ext_s = clk_pins[0];

  phase_timer u_timer (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .t(tif.tmr)
  );
  assign tif.start = s.timer_start;
  assign tif.load = s.timer_load;
  // span decode for width selection; codes 0 and 1 are both 2.5 V
  function automatic logic [1:0] span_code(input logic [1:0] f);
    span_code = (f == 2'h1) ? 2'h0 : f;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // live status folded into the readable word; reserved bits stay zero
  always_comb begin
    status_view = s.main_control_word & `CTL_RMASK;
    status_view[`BIT_SETTLED] = !i_param_change && i_clk_stable;
    status_view[`BIT_FILL] = (i_fill_count > i_threshold);
  end

  // sequencer, register file and derived strobes
  always_comb begin
    logic wr_hit;
    logic [31:0] w;
    wr_hit = 1'b0;
    w = '0;
    next_s = s;
    next_s.timer_start = 1'b0;
    next_s.init_pulse = 1'b0;
    next_s.conv_sync = 1'b0;
    next_s.ext_sync = 1'b0;
    next_s.buf_clr = 1'b0;
    // retry while configuration runs through its first (EEPROM) phase only
    next_s.retry = (s.st == board_ctl_pkg::ST_EEPROM);
    case (s.st)
      board_ctl_pkg::ST_IDLE: begin
        next_s.st = board_ctl_pkg::ST_EEPROM;
        next_s.timer_start = 1'b1;
        next_s.timer_load = EEPROM_CYC;
        next_s.retry = 1'b1;
      end
      board_ctl_pkg::ST_EEPROM: begin
        if (tif.done) begin
          next_s.st = board_ctl_pkg::ST_ROM;
          next_s.timer_start = 1'b1;
          next_s.timer_load = ROM_CYC;
          next_s.retry = 1'b0;
        end
      end
      board_ctl_pkg::ST_ROM: begin
        if (tif.done) begin
          next_s.st = board_ctl_pkg::ST_LOGIC;
          next_s.timer_start = 1'b1;
          next_s.timer_load = LOGIC_CYC;
        end
      end
      board_ctl_pkg::ST_LOGIC: begin
        if (tif.done) begin
          // defaults restored; pci rom state is never touched here
          next_s.main_control_word = `CTL_BOOT;
          next_s.main_control_word[`BIT_INIT] = 1'b1;
          next_s.init_pulse = 1'b1;
          next_s.buf_clr = 1'b1;
          next_s.st = board_ctl_pkg::ST_ADC;
          next_s.timer_start = 1'b1;
          next_s.timer_load = ADC_CYC;
        end
      end
      board_ctl_pkg::ST_ADC: begin
        if (tif.done) begin
          next_s.st = board_ctl_pkg::ST_RUN;
          next_s.main_control_word[`BIT_INIT] = 1'b0;
          next_s.main_control_word[`BIT_IRQ] = 1'b1;
          if (!s.soft_init) begin
            next_s.pci_irq_en = 1'b0;
          end
          next_s.soft_init = 1'b0;
        end
      end
      board_ctl_pkg::ST_RUN: begin
      end
      default: begin
        next_s.st = board_ctl_pkg::ST_IDLE;
      end
    endcase
    // register port
    wr_hit = i_wr && (i_addr == `CTL_OFFSET) && !s.retry;
    if (i_rd) begin
      next_s.rdata = (i_addr == `CTL_OFFSET) ? status_view : 32'h0;
    end
    if (wr_hit && s.st == board_ctl_pkg::ST_RUN) begin
      w = i_wdata & `CTL_WMASK;
      next_s.main_control_word[`BIT_IRQ] = s.main_control_word[`BIT_IRQ]
        & w[`BIT_IRQ];
      next_s.main_control_word[`BIT_CAL_OK] = s.main_control_word[`BIT_CAL_OK];
      next_s.main_control_word[10:0] = w[10:0];
      next_s.main_control_word[`BIT_SYNC] = 1'b0;
      next_s.main_control_word[23:16] = w[23:16];
      next_s.main_control_word[`BIT_INIT] = 1'b0;
      if (w[`BIT_SYNC]) begin
        if (w[`BIT_SYNC_CLR]) begin
          next_s.buf_clr = 1'b1;
        end else begin
          next_s.conv_sync = 1'b1;
          next_s.ext_sync = w[`BIT_INITIATOR];
        end
      end
      if (w[`BIT_INIT]) begin
        next_s.main_control_word[`BIT_INIT] = 1'b1;
        next_s.soft_init = 1'b1;
        next_s.st = board_ctl_pkg::ST_LOGIC;
        next_s.timer_start = 1'b1;
        next_s.timer_load = LOGIC_CYC;
      end
    end
    // hardware events win over a host clear in the same cycle
    if (i_irq_event) begin
      next_s.main_control_word[`BIT_IRQ] = 1'b1;
    end
    if (i_cal_start) begin
      next_s.main_control_word[`BIT_CAL_OK] = 1'b1;
    end else if (i_cal_fail) begin
      next_s.main_control_word[`BIT_CAL_OK] = 1'b0;
    end
    // clock output mux, initiator mode only
    if (!s.main_control_word[`BIT_INITIATOR]) begin
      next_s.clk_out = 1'b0;
    end else if (s.main_control_word[`BIT_CLK_SEL]) begin
      next_s.clk_out = gen_a_s;
    end else begin
      next_s.clk_out = grp0_ext_s ? gen_a_s : grp0_s;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
      s.st <= board_ctl_pkg::ST_IDLE;
      s.main_control_word <= `CTL_BOOT;
      s.retry <= 1'b1;
      s.timer_load <= 32'h1;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs from the state flops, simple gates on them, or constants
  assign o_rdata = s.rdata;
  assign o_retry = s.retry;
  assign o_irq = s.main_control_word[`BIT_IRQ];
  assign o_pci_irq_en = s.pci_irq_en;
  assign o_sync_scan = !s.main_control_word[`BIT_UNSYNC];
  assign o_converter_sync = s.conv_sync;
  assign o_ext_sync_out = s.ext_sync;
  assign o_buffer_clear = s.buf_clr;
  assign o_clk_out = s.clk_out;
  assign o_low_freq_filter = s.main_control_word[`BIT_LOWF];
  assign o_ttl_sync = s.main_control_word[`BIT_TTL];
  assign o_trig_armed = s.main_control_word[`BIT_ARM];
  assign o_trig_invert = s.main_control_word[`BIT_ARM]
    & s.main_control_word[`BIT_TRG_INV];
  assign o_input_function_field = s.main_control_word[1:0];
  assign o_span = span_code(s.main_control_word[3:2]);
  assign o_init_pulse = s.init_pulse;
  assign o_threshold_load = `THRESH_RESET;
  assign o_data_width_bits = 5'h10;
  assign o_rate_divisor = 8'h05;
  assign o_groups_on_a = 1'b1;
  assign o_initiator = s.main_control_word[`BIT_INITIATOR];

  ////////////////////////////////////////////////////////////////////////////
  property p_irq_set;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_irq_event |=> o_irq;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("irq not set");
  property p_cal_fail;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_cal_fail && !i_cal_start) |=> !s.main_control_word[`BIT_CAL_OK];
  endproperty
  a_cal_fail: assert property (p_cal_fail) else $error("cal ok stuck");
  property p_fill;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_rd && i_addr == `CTL_OFFSET && i_fill_count > i_threshold)
        |=> o_rdata[`BIT_FILL];
  endproperty
  a_fill: assert property (p_fill) else $error("fill flag wrong");
  logic wr_sync_clr;
  sequence s_clr_sync;
    wr_sync_clr ##1 o_buffer_clear && !o_converter_sync;
  endsequence
  assign wr_sync_clr = i_wr && i_addr == `CTL_OFFSET && !s.retry
    && s.st == board_ctl_pkg::ST_RUN && i_wdata[`BIT_SYNC]
    && i_wdata[`BIT_SYNC_CLR] && !i_wdata[`BIT_INIT];
  property p_sync_clr;
    @(posedge i_clk) disable iff (!i_rst_n)
      wr_sync_clr |-> s_clr_sync;
  endproperty
  a_sync_clr: assert property (p_sync_clr) else $error("no clear");
  property p_sync_self;
    @(posedge i_clk) disable iff (!i_rst_n)
      o_converter_sync |=> !o_converter_sync;
  endproperty
  a_sync_self: assert property (p_sync_self) else $error("sync held");
  property p_trig;
    @(posedge i_clk) disable iff (!i_rst_n)
      o_trig_invert |-> o_trig_armed;
  endproperty
  a_trig: assert property (p_trig) else $error("invert unarmed");
  property p_done_irq;
    @(posedge i_clk) disable iff (!i_rst_n)
      (s.st == board_ctl_pkg::ST_ADC && tif.done) |=> (o_irq
        && !s.main_control_word[`BIT_INIT] && s.st == board_ctl_pkg::ST_RUN);
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("init end");
  property p_retry;
    @(posedge i_clk) disable iff (!i_rst_n)
      (s.st == board_ctl_pkg::ST_RUN) |-> !o_retry;
  endproperty
  a_retry: assert property (p_retry) else $error("retry in run");
  property p_rsvd;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_rd |=> (o_rdata[31:24] == 8'h00 && o_rdata[22] == 1'b0);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved set");
endmodule
`default_nettype wire

// ### verilog/board_ctl_defines.svh
/*
  Offsets, field positions, reset values and timing counts for the board
  control block. Assumes a 125 MHz local clock.
*/
`ifndef BOARD_CTL_DEFINES_SVH
`define BOARD_CTL_DEFINES_SVH
`define CTL_OFFSET 8'h00
`define CTL_RESET 32'h0000383c
// word held through configuration: pending flag stays low until init ends
`define CTL_BOOT 32'h0000303c
// readable bits: the writable ones plus the calibration flag
`define CTL_RMASK 32'h00bf9fff
`define CTL_WMASK 32'h00bf8fff
`define BIT_IRQ 11
`define BIT_CAL_OK 12
`define BIT_SETTLED 13
`define BIT_FILL 14
`define BIT_INIT 15
`define BIT_UNSYNC 16
`define BIT_SYNC_CLR 17
`define BIT_CLK_SEL 18
`define BIT_LOWF 19
`define BIT_TTL 20
`define BIT_ARM 21
`define BIT_TRG_INV 23
`define BIT_SYNC 6
`define BIT_INITIATOR 5
`define THRESH_RESET 18'h3fffe
`define CLK_MHZ 125
`define EEPROM_MS 3
`define ROM_MS 300
`define LOGIC_MS 3
`define ADC_MS 5000
`define MS_CYC (`CLK_MHZ * 1000)
`endif

// ### verilog/board_ctl_pkg.sv
/*
  Types for the board control block. Assumes the defines header exists.
*/
package board_ctl_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_EEPROM = 6'b000010,
    ST_ROM = 6'b000100,
    ST_LOGIC = 6'b001000,
    ST_ADC = 6'b010000,
    ST_RUN = 6'b100000
  } cfg_state_t;
  typedef enum logic [1:0] {
    IN_DIFF = 2'h0,
    IN_RSVD = 2'h1,
    IN_GROUND = 2'h2,
    IN_VREF = 2'h3
  } input_mode_t;
endpackage

// ### verilog/phase_timer_if.sv
/*
  Carrier between the sequencer and its phase timer.
  Assumes a single clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface phase_timer_if;
  logic start;
  logic [31:0] load;
  logic done;
  modport ctl (output start, output load, input done);
  modport tmr (input start, input load, output done);
endinterface
`default_nettype wire

// ### verilog/phase_timer.sv
/*
  Down counter: start loads a cycle count, done pulses when it runs out.
  Assumes load is at least one.
*/
`timescale 1ns/1ps
`default_nettype none
module phase_timer (
  input wire logic i_clk,
  input wire logic i_rst_n,
  phase_timer_if.tmr t
);
  typedef struct packed {
    logic [31:0] cnt;
    logic busy;
    logic done;
  } tmr_state_t;
  tmr_state_t s, next_s;
  // count down; a fresh start overrides a running count
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (t.start) begin
      next_s.cnt = t.load;
      next_s.busy = 1'b1;
    end else if (s.busy) begin
      if (s.cnt <= 32'h1) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end else begin
        next_s.cnt = s.cnt - 32'h1;
      end
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign t.done = s.done;
endmodule
`default_nettype wire

// ### verilog/sync_2ff.sv
/*
  Two-flop synchroniser for pin levels. Assumes a slow-moving input.
*/
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] a;
    logic [W-1:0] b;
  } sync_state_t;
  sync_state_t s, next_s;
  // first stage feeds only the second
  always_comb begin
    next_s.a = i_d;
    next_s.b = s.a;
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign o_q = s.b;
endmodule
`default_nettype wire

// ### tb/host_model.sv
/*
  Host side of the register port: word writes at one clock, word reads at two.
  Assumes every task is entered at a falling edge and leaves at one.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic i_clk,
  input wire logic [31:0] i_rdata,
  input wire logic i_retry,
  input wire logic i_irq,
  output logic [7:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [31:0] o_wdata
);
  bit slow = 1'b0; // idle gaps before each request when set
  realtime last_end = 0.0; // when the latest write let go of the bus

  ////////////////////////////////////////////////////////////////////////
  // idle bus at time zero
  initial begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 32'h00000000;
  end

  // released lines show inverted values, so stale data never looks valid
  task automatic write(input logic [31:0] d);
    if (slow) repeat (2) @(negedge i_clk);
    // a write that just ended moved the lines in this step; let an edge pass
    if (last_end == $realtime) @(negedge i_clk);
    o_addr = 8'h00;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_wdata = ~d;
    o_addr = ~o_addr;
    last_end = $realtime;
  endtask

  // data is taken one edge after the strobe and holds until the next read
  task automatic read(input logic [7:0] a, output logic [31:0] d);
    if (slow) repeat (2) @(negedge i_clk);
    if (last_end == $realtime) @(negedge i_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk);
    o_rd = 1'b0;
    o_addr = ~a;
    @(negedge i_clk);
    d = i_rdata;
  endtask

  // stay off the bus while retried and until the init interrupt is up
  task automatic wait_ready(output int n);
    n = 0;
    while (n < 200 && !(i_retry === 1'b0 && i_irq === 1'b1)) begin
      @(negedge i_clk);
      n++;
    end
  endtask

  // self-test inputs need time to settle before samples are taken
  task automatic settle(input int cyc);
    repeat (cyc) @(negedge i_clk);
  endtask
endmodule
`default_nettype wire

// ### tb/test_board_control.sv
/*
  Self-checking bench for the board control word and its init sequencer.
  Assumes the shortened phase counts 4, 8, 4 and 16 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "board_ctl_defines.svh"
module test_board_control;
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_wr, i_rd, o_retry;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata, w, d;
  logic i_irq_event = 0, i_cal_start = 0, i_cal_fail = 0;
  logic i_param_change = 0, i_clk_stable = 1;
  logic [17:0] i_fill_count = 0, i_threshold = 18'h00010;
  logic i_gen_a_clk = 1, i_grp0_clk = 0, i_grp0_ext_clk = 0;
  logic o_irq, o_pci_irq_en, o_sync_scan, o_converter_sync, o_ext_sync_out;
  logic o_buffer_clear, o_clk_out, o_low_freq_filter, o_ttl_sync;
  logic o_trig_armed, o_trig_invert, o_init_pulse, o_groups_on_a, o_initiator;
  logic [1:0] o_input_function_field, o_span;
  logic [17:0] o_threshold_load;
  logic [4:0] o_data_width_bits;
  logic [7:0] o_rate_divisor;
  bit [31:0] m_ctl, seed = 32'h4f61;
  bit m_cal = 1'b1;
  int miscompares = 0, n_checks = 0, n;

  ////////////////////////////////////////////////////////////////////////
  always #4 i_clk = ~i_clk;

  board_control #(.EEPROM_CYC(4), .ROM_CYC(8), .LOGIC_CYC(4), .ADC_CYC(16))
  board_control_inst (.i_clk, .i_rst_n, .i_addr, .i_wr, .i_rd, .i_wdata,
    .o_rdata, .o_retry, .i_irq_event, .i_cal_start, .i_cal_fail,
    .i_param_change, .i_clk_stable, .i_fill_count, .i_threshold,
    .i_gen_a_clk, .i_grp0_clk, .i_grp0_ext_clk, .o_irq, .o_pci_irq_en,
    .o_sync_scan, .o_converter_sync, .o_ext_sync_out, .o_buffer_clear,
    .o_clk_out, .o_low_freq_filter, .o_ttl_sync, .o_trig_armed,
    .o_trig_invert, .o_input_function_field, .o_span, .o_init_pulse,
    .o_threshold_load, .o_data_width_bits, .o_rate_divisor, .o_groups_on_a,
    .o_initiator);

  host_model host_model_inst (.i_clk(i_clk), .i_rdata(o_rdata),
    .i_retry(o_retry), .i_irq(o_irq), .o_addr(i_addr), .o_wr(i_wr),
    .o_rd(i_rd), .o_wdata(i_wdata));

  ////////////////////////////////////////////////////////////////////////
  function automatic bit [31:0] lfsr(input bit [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // status bits come from live inputs; strobes read back zero once init has ended
  function automatic bit [31:0] exp_word();
    bit [31:0] e;
    e = m_ctl & ~32'h0000f040;
    e[12] = m_cal;
    e[13] = !i_param_change && i_clk_stable;
    e[14] = i_fill_count > i_threshold;
    return e;
  endfunction

  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask

  // writing one to the pending flag cannot raise it, only zero acts
  task automatic put(input bit [31:0] v);
    bit keep;
    keep = m_ctl[11] & v[11];
    m_ctl = (m_ctl & ~`CTL_WMASK) | (v & `CTL_WMASK);
    m_ctl[11] = keep;
    host_model_inst.write(v);
  endtask

  task automatic get_chk(input string s);
    host_model_inst.read(8'h00, d);
    chk(s, exp_word(), d);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge i_clk);
    s = 1'b0;
  endtask

  task automatic chk_pins();
    chk("sync_scan", 32'(!m_ctl[16]), 32'(o_sync_scan));
    chk("low_filter", 32'(m_ctl[19]), 32'(o_low_freq_filter));
    chk("ttl", 32'(m_ctl[20]), 32'(o_ttl_sync));
    chk("armed", 32'(m_ctl[21]), 32'(o_trig_armed));
    chk("inv", 32'(m_ctl[21] & m_ctl[23]), 32'(o_trig_invert));
    chk("func", 32'(m_ctl[1:0]), 32'(o_input_function_field));
    chk("span", 32'((m_ctl[3:2] == 2'h1) ? 2'h0 : m_ctl[3:2]),
      32'(o_span));
    chk("initiator", 32'(m_ctl[5]), 32'(o_initiator));
    chk("clk_out", 32'(m_ctl[5] & ((m_ctl[18] | i_grp0_ext_clk) ?
      i_gen_a_clk : i_grp0_clk)), 32'(o_clk_out));
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // hang guard: the sequence needs well under 2000 cycles
  initial begin
    #(8 * 5000);
    miscompares++;
    end_of_test();
  end

  // main sequence
  initial begin
    repeat (5) @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (2) @(negedge i_clk);
    chk("retry", 1, 32'(o_retry));
    host_model_inst.wait_ready(n);
    chk("cfg_len", 1, 32'(n >= 28 && n <= 40));
    chk("pci_irq_en", 0, 32'(o_pci_irq_en));
    m_ctl = `CTL_RESET;
    get_chk("word_reset");
    chk_pins();
    $display("test config done");
    // random control words; init and sync strobes kept out here
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      i_gen_a_clk = seed[11];
      i_grp0_clk = seed[7];
      i_grp0_ext_clk = seed[9];
      w = seed & ~32'h00008040;
      w[3:0] = i[3:0];
      put(w);
      if (w[1]) host_model_inst.settle(w[0] ? 6 : 2);
      get_chk("word_rand");
      chk_pins();
    end
    host_model_inst.read(8'h04, d);
    chk("unmapped", 0, d);
    $display("test fields done");
    pulse(i_irq_event);
    m_ctl[11] = 1'b1;
    chk("irq_set", 1, 32'(o_irq));
    put(m_ctl & ~32'h00000800);
    chk("irq_clr", 0, 32'(o_irq));
    put(m_ctl | 32'h00000800);
    chk("irq_keep", 0, 32'(o_irq));
    $display("test irq done");
    host_model_inst.slow = 1'b1;
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      i_fill_count = (i == 0) ? i_threshold : seed[17:0];
      get_chk("fill");
    end
    i_fill_count = i_threshold + 18'h00001;
    get_chk("fill_gt");
    i_param_change = 1'b1;
    get_chk("settling");
    i_param_change = 1'b0;
    i_clk_stable = 1'b0;
    get_chk("unstable");
    i_clk_stable = 1'b1;
    pulse(i_cal_fail);
    m_cal = 1'b0;
    get_chk("cal_fail");
    pulse(i_cal_start);
    m_cal = 1'b1;
    get_chk("cal_start");
    $display("test status done");
    for (int k = 0; k < 2; k++) begin
      put({m_ctl[31:18], k[0], m_ctl[16:0]} | 32'h00000060);
      chk("conv_sync", 32'(!k[0]), 32'(o_converter_sync));
      chk("ext_sync", 32'(!k[0]), 32'(o_ext_sync_out));
      chk("buf_clr", 32'(k[0]), 32'(o_buffer_clear));
      @(negedge i_clk);
      chk("sync_end", 0, 32'(o_converter_sync | o_buffer_clear));
      get_chk("word_sync");
    end
    $display("test sync done");
    put(32'h00008000);
    n = 0;
    while (o_init_pulse !== 1'b1 && n < 50) begin
      @(negedge i_clk);
      n++;
    end
    chk("init_pulse", 1, 32'(o_init_pulse));
    chk("init_clr", 1, 32'(o_buffer_clear));
    chk("thresh", 32'h0003fffe, 32'(o_threshold_load));
    chk("width", 16, 32'(o_data_width_bits));
    chk("divisor", 5, 32'(o_rate_divisor));
    chk("groups_a", 1, 32'(o_groups_on_a));
    m_ctl = `CTL_RESET;
    host_model_inst.read(8'h00, d);
    chk("init_busy", 32'h00008000, d & 32'h00008000);
    host_model_inst.wait_ready(n);
    chk("init_irq", 1, 32'(o_irq));
    get_chk("word_init");
    chk_pins();
    $display("test init done");
    end_of_test();
  end
endmodule
`default_nettype wire
